// [common/nvm_defs.svh]
// Purpose: Register offsets, control bit positions, reset values and timing for the NVM block
// Assumes: Byte-wide register port driven by the processor core
// Notes:   Definitions only
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

`define NVM_DATA_OFS        8'h08
`define NVM_ADDR_OFS        8'h09
`define NVM_CTRL_OFS        8'h88
`define NVM_UNLOCK_OFS      8'h89

`define NVM_BIT_DONE        4
`define NVM_BIT_ABORT       3
`define NVM_BIT_PERMIT      2
`define NVM_BIT_WSTROBE     1
`define NVM_BIT_RSTROBE     0

`define NVM_KEY_FIRST       8'h55
`define NVM_KEY_SECOND      8'hAA

`define NVM_CTRL_POR        8'h00
`define NVM_DEPTH           64
`define NVM_WRITE_CYCLES    16

`endif

// [common/nvm_pkg.sv]
// Purpose: Types for both ends of the NVM register link, one enum per end
// Assumes: Offsets and figures live in nvm_defs.svh
// Notes:   No imports anywhere; use nvm_pkg::name
package nvm_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } key_state_e;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_RD_STROBE,
        HST_RD_FETCH,
        HST_WR_ADDR,
        HST_WR_DATA,
        HST_WR_KEY1,
        HST_WR_KEY2,
        HST_WR_POLL
    } host_state_e;
endpackage

// [common/nvm_if.sv]
// Purpose: Register port between the processor core and the NVM block
// Assumes: One clock; write and read are single-cycle strobes
// Notes:   Read data is registered in the device
`timescale 1ns/1ps
interface nvm_if;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       irq_flag;

    modport dev  (input wr_en, input rd_en, input addr, input wdata,
                  output rdata, output irq_flag);
    modport core (output wr_en, output rd_en, output addr, output wdata,
                  input rdata, input irq_flag);
endinterface

// [hdl/nvm_access.sv]
// Purpose: Data NVM access control: address, data, control and unlock registers
// Assumes: Single clock; core issues at most one register access per cycle
// Notes:   Array write time is modelled by an internal cycle counter
`timescale 1ns/1ps
`include "nvm_defs.svh"

// Summary of operation
// - Array holds 64 bytes addressed by address
// - Read strobe loads data register next cycle unless a write is running
// - Data register holds until read or write
// - Core sets address and data before writing
// - Write starts only after 55h, AAh, strobe
// - Core keeps interrupts off during unlock
// - Write strobe needs permit already set
// - Hardware clears permit only on a reset
// - Clearing permit does not stop write
// - Completion clears strobe, sets done flag
// - Done flag stays until core clears
// - Control bits: done, abort, permit, strobes
// - nrst zeroes all registers but not the array; warm reset keeps address, data
module nvm_access #(
    parameter int DEPTH        = `NVM_DEPTH,
    parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic warm_reset,
    nvm_if.dev        bus
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(WRITE_CYCLES + 1);

    typedef struct packed {
        logic [7:0]           data;
        logic [7:0]           addr;
        logic                 done;
        logic                 abort;
        logic                 permit;
        logic                 wstrobe;
        nvm_pkg::key_state_e  key;
        logic [CW-1:0]        cnt;
        logic [7:0]           rdata;
    } state_s;

    state_s     st_r;
    state_s     st_nxt;
    logic [7:0] mem [DEPTH];
    logic       mem_we;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [7:0] ctrl_view(input state_s s);
        return {3'h0, s.done, s.abort, s.permit, s.wstrobe, 1'b0};
    endfunction

    always_comb begin
        st_nxt = st_r;
        mem_we = 1'b0;
        if (st_r.wstrobe) begin
            // Permit is not consulted here, so dropping it mid-write is harmless
            if (st_r.cnt == CW'(WRITE_CYCLES - 1)) begin
                mem_we       = 1'b1;
                st_nxt.wstrobe = 1'b0;
                st_nxt.done    = 1'b1;
                st_nxt.cnt     = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end
        if (bus.wr_en) begin
            if (hit(bus.addr, `NVM_DATA_OFS)) begin
                st_nxt.data = bus.wdata;
                st_nxt.key  = nvm_pkg::KEY_IDLE;
            end else if (hit(bus.addr, `NVM_ADDR_OFS)) begin
                st_nxt.addr = bus.wdata;
                st_nxt.key  = nvm_pkg::KEY_IDLE;
            end else if (hit(bus.addr, `NVM_UNLOCK_OFS)) begin
                // Only the sequence position is kept, never the byte
                case (st_r.key)
                    nvm_pkg::KEY_IDLE:
                        st_nxt.key = (bus.wdata == `NVM_KEY_FIRST) ?
                                     nvm_pkg::KEY_GOT_FIRST : nvm_pkg::KEY_IDLE;
                    nvm_pkg::KEY_GOT_FIRST:
                        st_nxt.key = (bus.wdata == `NVM_KEY_SECOND) ?
                                     nvm_pkg::KEY_ARMED : nvm_pkg::KEY_IDLE;
                    default:
                        st_nxt.key = (bus.wdata == `NVM_KEY_FIRST) ?
                                     nvm_pkg::KEY_GOT_FIRST : nvm_pkg::KEY_IDLE;
                endcase
            end else if (hit(bus.addr, `NVM_CTRL_OFS)) begin
                st_nxt.key    = nvm_pkg::KEY_IDLE;
                st_nxt.permit = bus.wdata[`NVM_BIT_PERMIT];
                st_nxt.abort  = bus.wdata[`NVM_BIT_ABORT];
                // Hardware set wins over a same-cycle software clear
                if (!mem_we)
                    st_nxt.done = bus.wdata[`NVM_BIT_DONE];
                if (bus.wdata[`NVM_BIT_WSTROBE] && !st_r.wstrobe
                    && st_r.permit
                    && st_r.key == nvm_pkg::KEY_ARMED) begin
                    st_nxt.wstrobe = 1'b1;
                    st_nxt.cnt     = '0;
                end
                if (bus.wdata[`NVM_BIT_RSTROBE] && !st_r.wstrobe)
                    st_nxt.data = mem[st_r.addr[AW-1:0]];
            end else begin
                st_nxt.key = nvm_pkg::KEY_IDLE;
            end
        end
        st_nxt.rdata = 8'h00;
        if (bus.rd_en) begin
            if (hit(bus.addr, `NVM_DATA_OFS))
                st_nxt.rdata = st_nxt.data;
            else if (hit(bus.addr, `NVM_ADDR_OFS))
                st_nxt.rdata = st_nxt.addr;
            else if (hit(bus.addr, `NVM_CTRL_OFS))
                st_nxt.rdata = ctrl_view(st_nxt);
            else
                st_nxt.rdata = 8'h00;
        end
        if (warm_reset) begin
            // Warm reset keeps address and data; done flag is condition-held
            st_nxt.permit  = 1'b0;
            st_nxt.wstrobe = 1'b0;
            st_nxt.cnt     = '0;
            st_nxt.key     = nvm_pkg::KEY_IDLE;
            st_nxt.abort   = st_r.wstrobe;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && mem_we && !warm_reset)
            mem[st_r.addr[AW-1:0]] <= st_r.data;
    end

    always_comb begin
        bus.rdata    = st_r.rdata;
        bus.irq_flag = st_r.done;
    end
endmodule // nvm_access

// [hdl/nvm_core_end.sv]
// Purpose: Processor-side sequencer issuing NVM reads and unlocked writes
// Assumes: User pulses start with a command; interrupts are masked by caller
// Notes:   Register port carries one access per cycle
`timescale 1ns/1ps
`include "nvm_defs.svh"

module nvm_core_end (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       write,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rdata,
    nvm_if.core             bus
);
    typedef struct packed {
        nvm_pkg::host_state_e st;
        logic                 issued;
        logic [7:0]           addr;
        logic [7:0]           data;
        logic                 done;
        logic                 wr_en;
        logic                 rd_en;
        logic [7:0]           baddr;
        logic [7:0]           bdata;
    } host_s;

    host_s h_r;
    host_s h_nxt;

    function automatic logic [7:0] ctrl_bits(input logic perm, input logic ws, input logic rs);
        return {5'h00, perm, ws, rs};
    endfunction

    always_comb begin
        h_nxt       = h_r;
        h_nxt.done  = 1'b0;
        h_nxt.wr_en = 1'b0;
        h_nxt.rd_en = 1'b0;
        case (h_r.st)
            nvm_pkg::HST_IDLE: begin
                if (start) begin
                    h_nxt.addr  = addr;
                    h_nxt.data  = wdata;
                    h_nxt.wr_en = 1'b1;
                    h_nxt.baddr = `NVM_ADDR_OFS;
                    h_nxt.bdata = addr;
                    h_nxt.st    = write ? nvm_pkg::HST_WR_ADDR : nvm_pkg::HST_RD_STROBE;
                end
            end
            nvm_pkg::HST_RD_STROBE: begin
                h_nxt.wr_en = 1'b1;
                h_nxt.baddr = `NVM_CTRL_OFS;
                h_nxt.bdata = ctrl_bits(1'b0, 1'b0, 1'b1);
                h_nxt.st    = nvm_pkg::HST_RD_FETCH;
                h_nxt.issued = 1'b0;
            end
            nvm_pkg::HST_RD_FETCH: begin
                if (!h_r.issued) begin
                    h_nxt.rd_en  = 1'b1;
                    h_nxt.baddr  = `NVM_DATA_OFS;
                    h_nxt.issued = 1'b1;
                end else if (!h_r.rd_en) begin
                    // Registered read data stands one cycle after the read pulse
                    h_nxt.data = bus.rdata;
                    h_nxt.done = 1'b1;
                    h_nxt.st   = nvm_pkg::HST_IDLE;
                end
            end
            nvm_pkg::HST_WR_ADDR: begin
                h_nxt.wr_en = 1'b1;
                h_nxt.baddr = `NVM_DATA_OFS;
                h_nxt.bdata = h_r.data;
                h_nxt.st    = nvm_pkg::HST_WR_DATA;
            end
            nvm_pkg::HST_WR_DATA: begin
                h_nxt.wr_en = 1'b1;
                h_nxt.baddr = `NVM_CTRL_OFS;
                h_nxt.bdata = ctrl_bits(1'b1, 1'b0, 1'b0);
                h_nxt.st    = nvm_pkg::HST_WR_KEY1;
            end
            nvm_pkg::HST_WR_KEY1: begin
                h_nxt.wr_en = 1'b1;
                h_nxt.baddr = `NVM_UNLOCK_OFS;
                // Sequencer raises no interrupt between the unlock writes
                h_nxt.bdata = `NVM_KEY_FIRST;
                h_nxt.st    = nvm_pkg::HST_WR_KEY2;
            end
            nvm_pkg::HST_WR_KEY2: begin
                h_nxt.wr_en = 1'b1;
                h_nxt.baddr = `NVM_UNLOCK_OFS;
                h_nxt.bdata = `NVM_KEY_SECOND;
                h_nxt.st    = nvm_pkg::HST_WR_POLL;
                h_nxt.issued = 1'b0;
            end
            default: begin
                if (!h_r.issued) begin
                    h_nxt.wr_en  = 1'b1;
                    h_nxt.baddr  = `NVM_CTRL_OFS;
                    h_nxt.bdata  = ctrl_bits(1'b1, 1'b1, 1'b0);
                    h_nxt.issued = 1'b1;
                end else if (bus.irq_flag) begin
                    // Clear done flag and drop permit in one write
                    h_nxt.wr_en = 1'b1;
                    h_nxt.baddr = `NVM_CTRL_OFS;
                    h_nxt.bdata = 8'h00;
                    h_nxt.done  = 1'b1;
                    h_nxt.st    = nvm_pkg::HST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            h_r <= '0;
        end else if (ce) begin
            h_r <= h_nxt;
        end
    end

    always_comb begin
        bus.wr_en = h_r.wr_en;
        bus.rd_en = h_r.rd_en;
        bus.addr  = h_r.baddr;
        bus.wdata = h_r.bdata;
        busy      = h_r.st != nvm_pkg::HST_IDLE;
        done      = h_r.done;
        rdata     = h_r.data;
    end
endmodule // nvm_core_end

// [test/nvm_link_checker.sv]
// Purpose: Concurrent checks on the NVM register link
// Assumes: Both link ends are design code on one clock
// Notes:   WC must equal the device write time parameter
`timescale 1ns/1ps
module nvm_link_checker #(
    parameter int WC = 16
) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       irq_flag
);
    localparam int LO = WC - 1;
    localparam int HI = WC + 8;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_key(logic [7:0] k);
        wr_en && addr == 8'h89 && wdata == k;
    endsequence
    sequence s_strobe;
        wr_en && addr == 8'h88 && wdata[1];
    endsequence
    property p_key_order;
        s_strobe |-> $past(wr_en && addr == 8'h89 && wdata == 8'hAA)
            && $past(wr_en && addr == 8'h89 && wdata == 8'h55, 2);
    endproperty
    a_key_order: assert property (p_key_order) else $error("strobe without key");
    property p_setup;
        s_strobe |-> $past(wr_en && addr == 8'h09, 5) && $past(wr_en && addr == 8'h08, 4)
            && $past(wr_en && addr == 8'h88 && wdata[2], 3);
    endproperty
    a_setup: assert property (p_setup) else $error("strobe without setup");
    // Window allows a few cycles of core polling slack
    property p_done_time;
        s_key(8'h55) ##1 s_key(8'hAA) ##1 s_strobe |-> ##[LO:HI] $rose(irq_flag);
    endproperty
    a_done_time: assert property (p_done_time) else $error("write never finished");
    property p_done_hold;
        irq_flag && !(wr_en && addr == 8'h88 && !wdata[4]) |=> irq_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done flag dropped");
    property p_done_clear;
        wr_en && addr == 8'h88 && !wdata[4] |=> !irq_flag;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");
    property p_ctrl_read;
        rd_en && addr == 8'h88 |=> rdata[7:5] == 3'h0 && !rdata[0];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("bad control read");
    property p_read_order;
        rd_en && addr == 8'h08 |-> $past(wr_en && addr == 8'h88 && wdata == 8'h01)
            && $past(wr_en && addr == 8'h09, 2);
    endproperty
    a_read_order: assert property (p_read_order) else $error("bad read order");
    property p_one_access;
        !(wr_en && rd_en);
    endproperty
    a_one_access: assert property (p_one_access) else $error("two accesses");
endmodule // nvm_link_checker

// [test/data_eeprom_access_control_bench.sv]
// Purpose: Self-checking bench for both NVM link ends
// Assumes: Core end handles unlock; short write time
// Notes:   Only written bytes are read back
`timescale 1ns/1ps
module data_eeprom_access_control_bench;
    localparam int WC = 4;
    logic       clk = 1'h0;
    logic       nrst = 1'h0;
    logic       start = 1'h0;
    logic       warm_reset = 1'h0;
    logic       write = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       busy;
    logic       done;
    logic [7:0] rdata;
    logic [7:0] mem [64];
    logic [5:0] a;
    logic [7:0] d;
    int         failures = 0;
    int         n_compared = 0;
    nvm_if bus ();
    always #4 clk = ~clk;
    // Clock enable held high; freezing would skew the checker's history
    nvm_access #(.DEPTH(64), .WRITE_CYCLES(WC)) i_nvm_access (.clk(clk), .nrst(nrst),
        .ce(1'h1), .warm_reset(warm_reset), .bus(bus));
    nvm_core_end i_nvm_core_end (.clk(clk), .nrst(nrst), .ce(1'h1), .start(start),
        .write(write), .addr(addr), .wdata(wdata), .busy(busy), .done(done),
        .rdata(rdata), .bus(bus));
    nvm_link_checker #(.WC(WC)) i_nvm_link_checker (.clk(clk), .nrst(nrst),
        .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata),
        .rdata(bus.rdata), .irq_flag(bus.irq_flag));
    function automatic logic [7:0] expect_byte(input logic [5:0] x);
        return mem[x];
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic op(input logic wr, input logic [5:0] x, input logic [7:0] v);
        int n;
        n = 0;
        @(negedge clk);
        start = 1'h1;
        write = wr;
        addr = {2'h0, x};
        wdata = v;
        @(negedge clk);
        start = 1'h0;
        while (done !== 1'h1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) failures++;
        if (wr) mem[x] = v;
        else check("read byte", rdata, expect_byte(x));
        repeat (2) @(negedge clk);
        check("done flag", {7'h00, bus.irq_flag}, 8'h00);
        check("busy", {7'h00, busy}, 8'h00);
    endtask
    initial begin
        void'($urandom(75829));
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst = 1'h1;
        // Boundary addresses and overwrite of a fresh byte
        op(1'h1, 6'h00, 8'h00);
        op(1'h1, 6'h3F, 8'hFF);
        op(1'h1, 6'h05, 8'hA5);
        op(1'h1, 6'h05, 8'h5A);
        op(1'h0, 6'h00, 8'h00);
        op(1'h0, 6'h3F, 8'h00);
        op(1'h0, 6'h05, 8'h00);
        // Warm reset keeps array contents; the readback rewrites address and data
        @(negedge clk);
        warm_reset = 1'h1;
        @(negedge clk);
        warm_reset = 1'h0;
        op(1'h0, 6'h05, 8'h00);
        for (int i = 0; i < 30; i++) begin
            a = 6'($urandom_range(63));
            d = 8'($urandom);
            op(1'h1, a, d);
            op(1'h0, a, 8'h00);
            op(1'h0, a, 8'h00);
            op(1'h0, 6'h3F, 8'h00);
        end
        end_sim;
    end
    initial begin
        #(8 * 20000);
        failures++;
        end_sim;
    end
endmodule // data_eeprom_access_control_bench
